// ---- tick_calib_and_irq_enable_set.sv ----
// Calibration word and set-only interrupt enable register for interrupts 0 to 31.
// Assumes software drives reg_req synchronously to clk, one strobe per cycle.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module tick_calib_and_irq_enable_set #(
  parameter logic [23:0] RELOAD_CONST = tick_calib_pkg::TEN_MILLISECOND_RELOAD,
  parameter int IRQ_COUNT = tick_calib_pkg::IRQ_N
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire tick_calib_pkg::reg_req_t reg_req,
  output logic [31:0] rdata,
  output logic rvalid,
  // Block outputs
  output logic [IRQ_COUNT-1:0] interrupt_enable,
  output logic ref_tick
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit_cal;
  logic hit_en;
  logic [31:0] cal_word;

  assign hit_cal = (reg_req.addr == tick_calib_pkg::OFS_TICK_TIMER_CALIBRATION);
  assign hit_en = (reg_req.addr == tick_calib_pkg::OFS_IRQ_ENABLE_SET_LOW);

  // The calibration word is fixed; writes to it have no effect.
  always_comb begin
    cal_word = 32'h0000_0000;
    cal_word[tick_calib_pkg::NO_REFERENCE_FLAG_POS] =
      tick_calib_pkg::NO_REFERENCE_RESET;
    cal_word[tick_calib_pkg::CALIBRATION_INEXACT_FLAG_POS] =
      tick_calib_pkg::CALIBRATION_INEXACT_RESET;
    cal_word[tick_calib_pkg::RELOAD_W-1:0] = RELOAD_CONST;
  end

  // ----------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------
  logic [IRQ_COUNT-1:0] enable_r;
  logic [IRQ_COUNT-1:0] enable_nxt;

  always_comb begin
    enable_nxt = enable_r;
    if (reg_req.wr && hit_en) begin
      enable_nxt = enable_r | reg_req.wdata[IRQ_COUNT-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      enable_r <= tick_calib_pkg::IRQ_ENABLE_RESET[IRQ_COUNT-1:0];
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // Bit n of the register drives the enable of interrupt n.
  assign interrupt_enable = enable_r;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  always_comb begin
    rdata_nxt = tick_calib_pkg::READ_IDLE;
    rvalid_nxt = reg_req.rd;
    if (reg_req.rd && hit_cal) begin
      rdata_nxt = cal_word;
    end else if (reg_req.rd && hit_en) begin
      rdata_nxt = 32'h0000_0000;
      rdata_nxt[IRQ_COUNT-1:0] = enable_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= tick_calib_pkg::READ_IDLE;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;

  // ----------------------------------------------------------------
  // Reference clock divider
  // ----------------------------------------------------------------
  logic [tick_calib_pkg::REF_DIV_W-1:0] div_r;
  logic [tick_calib_pkg::REF_DIV_W-1:0] div_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    tick_nxt = (div_r == tick_calib_pkg::REF_DIV_LAST);
    if (div_r == tick_calib_pkg::REF_DIV_LAST) begin
      div_nxt = tick_calib_pkg::REF_DIV_RESET;
    end else begin
      div_nxt = div_r + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_r <= tick_calib_pkg::REF_DIV_RESET;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign ref_tick = tick_r;

  // ----------------------------------------------------------------
  // Assertion helpers
  // ----------------------------------------------------------------
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;
  logic seen_r;
  logic seen_nxt;

  always_comb begin
    gap_nxt = gap_r + 8'h01;
    seen_nxt = seen_r;
    if (tick_r) begin
      gap_nxt = 8'h01;
      seen_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      seen_r <= seen_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rstn);

  sequence s_cal_read;
    reg_req.rd && hit_cal;
  endsequence

  sequence s_en_read;
    reg_req.rd && hit_en;
  endsequence

  sequence s_en_write;
    reg_req.wr && hit_en;
  endsequence

  sequence s_released;
    rstn && $past(!rstn);
  endsequence

  sequence s_unmapped_read;
    reg_req.rd && !hit_cal && !hit_en;
  endsequence

  sequence s_stray_write;
    rstn && reg_req.wr && !hit_en;
  endsequence

  property p_no_reference;
    s_cal_read |=> rvalid && !rdata[31];
  endproperty
  a_no_reference: assert property (p_no_reference) else $error("Reference flag not zero.");

  property p_inexact;
    s_cal_read |=> rvalid && !rdata[30] && rdata[29:24] == 6'h00;
  endproperty
  a_inexact: assert property (p_inexact) else $error("Inexact flag not zero.");

  property p_reload;
    s_cal_read |=> rdata[23:0] == 24'hc35;
  endproperty
  a_reload: assert property (p_reload) else $error("Reload constant wrong.");

  property p_cal_read_twice;
    s_cal_read ##1 s_cal_read |=> rvalid && rdata == $past(rdata);
  endproperty
  a_cal_read_twice: assert property (p_cal_read_twice) else $error("Calibration read unstable.");

  property p_rvalid_on_read;
    reg_req.rd |=> rvalid;
  endproperty
  a_rvalid_on_read: assert property (p_rvalid_on_read) else $error("Read not answered.");

  property p_rvalid_idle;
    !reg_req.rd |=> !rvalid;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("Answer without read.");

  property p_rdata_idle;
    !reg_req.rd |=> rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside answer.");

  property p_unmapped_read;
    s_unmapped_read |=> rvalid && rdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero.");

  property p_stray_write;
    s_stray_write |=> $stable(interrupt_enable);
  endproperty
  a_stray_write: assert property (p_stray_write) else $error("Other write changed enables.");

  property p_enable_hold;
    rstn |=> (interrupt_enable & $past(interrupt_enable)) == $past(interrupt_enable);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("Enable cleared without reset.");

  property p_write_then_read;
    s_en_write ##1 s_en_read |=>
      (rdata[IRQ_COUNT-1:0] & $past(reg_req.wdata[IRQ_COUNT-1:0], 2))
      == $past(reg_req.wdata[IRQ_COUNT-1:0], 2);
  endproperty
  a_write_then_read: assert property (p_write_then_read) else $error("Read missed new enable.");

  property p_first_tick;
    s_released |-> !ref_tick ##32 ref_tick;
  endproperty
  a_first_tick: assert property (p_first_tick) else $error("First tick not 32 after reset.");

  property p_cal_ro;
    (reg_req.wr && hit_cal) ##1 s_cal_read |=> rdata[23:0] == 24'hc35;
  endproperty
  a_cal_ro: assert property (p_cal_ro) else $error("Calibration word changed.");

  property p_map;
    s_en_read |=> rdata == 32'(interrupt_enable);
  endproperty
  a_map: assert property (p_map) else $error("Read does not match enables.");

  property p_set;
    s_en_write |=> (interrupt_enable & $past(reg_req.wdata[IRQ_COUNT-1:0]))
      == $past(reg_req.wdata[IRQ_COUNT-1:0]);
  endproperty
  a_set: assert property (p_set) else $error("Written one did not enable.");

  property p_keep;
    s_en_write |=> (interrupt_enable & ~$past(reg_req.wdata[IRQ_COUNT-1:0]))
      == ($past(interrupt_enable) & ~$past(reg_req.wdata[IRQ_COUNT-1:0]));
  endproperty
  a_keep: assert property (p_keep) else $error("Zero bit changed an enable.");

  property p_no_clear;
    rstn && !(reg_req.wr && hit_en) |=> $stable(interrupt_enable);
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("Enable changed unasked.");

  property p_read_twice;
    s_en_read ##1 s_en_read |=> rdata == $past(rdata) || $past(reg_req.wr);
  endproperty
  a_read_twice: assert property (p_read_twice) else $error("Enable read unstable.");

  property p_tick_gap;
    ref_tick && seen_r |-> gap_r == 8'(tick_calib_pkg::REF_DIV);
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("Tick period not 32.");

  property p_tick_pulse;
    ref_tick |=> !ref_tick [*8];
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("Tick too wide.");

  property p_reset_clear;
    $past(!rstn) |-> interrupt_enable == '0 && !ref_tick;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Enables set after reset.");

endmodule

// ---- tick_calib_pkg.sv ----
// Constants and carrier types for the tick calibration and enable block.
// Assumes a single 25 MHz clock and a plain single-cycle register port.
package tick_calib_pkg;

  // ----------------------------------------------------------------
  // Register port widths and offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_TICK_TIMER_CALIBRATION = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_SET_LOW = 8'h04;

  // ----------------------------------------------------------------
  // Calibration word layout
  // ----------------------------------------------------------------
  localparam int NO_REFERENCE_FLAG_POS = 31;
  localparam int CALIBRATION_INEXACT_FLAG_POS = 30;
  localparam int RELOAD_W = 24;
  localparam logic [23:0] TEN_MILLISECOND_RELOAD = 24'hc35;
  localparam logic NO_REFERENCE_RESET = 1'h0;
  localparam logic CALIBRATION_INEXACT_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Enable register and reference divider
  // ----------------------------------------------------------------
  localparam int IRQ_N = 32;
  localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0000;
  localparam int REF_DIV = 32;
  localparam int REF_DIV_W = 5;
  localparam logic [4:0] REF_DIV_LAST = 5'h1f;
  localparam logic [4:0] REF_DIV_RESET = 5'h00;
  localparam logic [31:0] READ_IDLE = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ---- tb_tick_calib_and_irq_enable_set.sv ----
// Self-checking bench for the calibration word and set-only interrupt enable block.
// Assumes the block package is compiled first and one 25 MHz clock.
`timescale 1ns/1ps

module tb_tick_calib_and_irq_enable_set;
  // ----------------------------------------------------------------
  // Signals, table and device
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] wdata;
    logic [31:0] en;
  } row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  tick_calib_pkg::reg_req_t reg_req = '0;
  logic [31:0] rdata;
  logic rvalid;
  logic [31:0] interrupt_enable;
  logic ref_tick;
  logic [31:0] exp_en;
  int err_total = 0;
  int tests_run = 0;
  int gap;
  row_t rows [5] = '{'{32'h0000_0001, 32'h0000_0001}, '{32'h8000_0000, 32'h8000_0001},
    '{32'h0000_0000, 32'h8000_0001}, '{32'h00ff_0000, 32'h80ff_0001},
    '{32'h5a5a_5a5a, 32'hdaff_5a5b}};
  localparam logic [7:0] CAL = tick_calib_pkg::OFS_TICK_TIMER_CALIBRATION;
  localparam logic [7:0] ENA = tick_calib_pkg::OFS_IRQ_ENABLE_SET_LOW;

  tick_calib_and_irq_enable_set u_dut (
    .clk(clk),
    .rstn(rstn),
    .reg_req(reg_req),
    .rdata(rdata),
    .rvalid(rvalid),
    .interrupt_enable(interrupt_enable),
    .ref_tick(ref_tick)
  );

  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Compare, bus, tick wait and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    chk_bit("rvalid", 1'b1, rvalid);
    chk_word("rdata", exp, rdata);
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ref_tick !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      wrap_up();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk_word("enable after reset", 32'h0, interrupt_enable);
    chk_bit("rvalid idle", 1'b0, rvalid);
    rd_reg(CAL, 32'h0000_0c35);
    wr_reg(CAL, 32'hffff_ffff);
    rd_reg(CAL, 32'h0000_0c35);
    rd_reg(ENA, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr_reg(ENA, rows[i].wdata);
      chk_word("interrupt_enable", rows[i].en, interrupt_enable);
      rd_reg(ENA, rows[i].en);
    end
    wr_reg(8'h08, 32'hffff_ffff);
    rd_reg(8'h08, 32'h0);
    chk_word("enable after stray write", rows[4].en, interrupt_enable);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk_word("enable after second reset", 32'h0, interrupt_enable);
    @(posedge clk);
    reg_req.addr <= ENA;
    reg_req.wdata <= 32'h0000_8001;
    reg_req.wr <= 1'b1;
    @(posedge clk);
    reg_req.wr <= 1'b0;
    reg_req.rd <= 1'b1;
    @(posedge clk);
    #1;
    chk_word("back to back read", 32'h0000_8001, rdata);
    @(posedge clk);
    reg_req.addr <= CAL;
    reg_req.rd <= 1'b0;
    reg_req.wr <= 1'b1;
    #1;
    chk_word("second enable read", 32'h0000_8001, rdata);
    @(posedge clk);
    reg_req.wr <= 1'b0;
    reg_req.rd <= 1'b1;
    @(posedge clk);
    #1;
    chk_word("calibration after write", 32'h0000_0c35, rdata);
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    chk_word("calibration read again", 32'h0000_0c35, rdata);
    exp_en = 32'h0000_8001;
    for (int i = 0; i < 32; i++) begin
      wr_reg(ENA, 32'h1 << i);
      exp_en = exp_en | (32'h1 << i);
      chk_word("single bit enable", exp_en, interrupt_enable);
    end
    wait_tick(gap);
    wait_tick(gap);
    chk_word("tick period", 32'h20, 32'(gap));
    @(posedge clk);
    #1;
    chk_bit("tick width", 1'b0, ref_tick);
    wrap_up();
  end
endmodule
